// ### adcpt_ctrl.sv
// Purpose: Power, trigger and interrupt control of an 8-channel converter
// Assumes: Single clock, AXI4-Lite register access, wait and trigger from pins
// Notes: Conversion timing is modelled by a counter; result data come from RESULT_DATA
`timescale 1ns/1ns
`default_nettype none
`include "adcpt_defs.svh"

// Function
// - Control two write aborts, never starts sequence
// - Control three write aborts, never starts sequence
// - Power bit zero powers converter down
// - Recovery period after power-up before converting, cut short by a control two or three write
// - Normal clear: status read then result read
// - Fast clear: any result access clears flag
// - Wait power-down bit halts converter in wait
// - Leaving wait resumes the halted conversion
// - Level/edge and polarity select trigger sensitivity
// - Trigger enable takes trigger from channel 7
// - Interrupt enable requests on sequence complete flag
// - Interrupt flag mirrors complete flag when enabled
// - Writes to interrupt flag bit are ignored
// - Abort resets result placement counter; restart keeps it
module adcpt_ctrl #(
  parameter int RECOVERY_CYC = `ADCPT_RECOVERY_CYC,
  parameter int SEQ_LEN = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // AXI4-Lite write address and data
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Pins and converter side
  input wire logic TRIG_CH7,
  input wire logic WAIT_MODE,
  input wire logic [9:0] RESULT_DATA,
  output logic ANALOG_POWER,
  output logic CONV_ACTIVE,
  output logic [2:0] RESULT_SLOT,
  output logic IRQ,
  output logic SEQ_IRQ
);

  // ****************************************
  // State registers
  // ****************************************
  adcpt_pkg::adcpt_state_all_t s_q; // Registered state
  adcpt_pkg::adcpt_state_all_t s_d; // Next state
  logic [9:0] result_q [8]; // Result registers

  // Result register access decoder, used for reads and writes
  function automatic logic is_result(input logic [7:0] a);
    is_result = (a[7:5] == 3'(`ADCPT_RESULT_BASE >> 5)) && (a[1:0] == 2'b00);
  endfunction : is_result

  // Trigger sensitivity evaluation
  function automatic logic trig_hit(input logic le, input logic pol, input logic cur,
                                    input logic prev);
    if (le) begin
      trig_hit = (cur == pol);
    end else begin
      trig_hit = pol ? (cur && !prev) : (!cur && prev);
    end
  endfunction : trig_hit

  logic aw_take; // Address accepted
  logic w_take; // Data accepted
  logic wr_go; // Both halves present
  logic rd_go; // Read accepted
  logic [3:0] wr_idx; // Write register index
  logic [3:0] rd_idx; // Read register index
  logic halt; // Converter held in wait
  logic trig_fire; // Trigger event
  logic seq_flag; // Interrupt flag view

  assign aw_take = AWVALID && !s_q.wr.aw_v && !s_q.bvalid;
  assign w_take = WVALID && !s_q.wr.w_v && !s_q.bvalid;
  assign AWREADY = !s_q.wr.aw_v && !s_q.bvalid;
  assign WREADY = !s_q.wr.w_v && !s_q.bvalid;
  assign ARREADY = !s_q.rvalid;
  assign rd_go = ARVALID && !s_q.rvalid;
  assign wr_go = s_q.wr.aw_v && s_q.wr.w_v;
  assign wr_idx = s_q.wr.aw_a[5:2];
  assign rd_idx = ARADDR[5:2];
  assign halt = s_q.ctrl2[`ADCPT_B_WAITPD] && s_q.wait_s2;
  assign seq_flag = s_q.ctrl2[`ADCPT_B_IRQEN] && s_q.sequence_complete_flag;
  assign trig_fire = s_q.ctrl2[`ADCPT_B_TRIGE] && trig_hit(s_q.ctrl2[`ADCPT_B_TRIGLE],
                     s_q.ctrl2[`ADCPT_B_TRIGP], s_q.trig_s2, s_q.trig_prev);

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic abort;
    logic [7:0] wd;
    logic [2:0] rslot;
    abort = 1'b0;
    wd = 8'h00;
    rslot = 3'd0;
    s_d = s_q;
    // Synchronisers for pins
    s_d.trig_s1 = TRIG_CH7;
    s_d.trig_s2 = s_q.trig_s1;
    s_d.trig_prev = s_q.trig_s2;
    s_d.wait_s1 = WAIT_MODE;
    s_d.wait_s2 = s_q.wait_s1;
    // Capture write halves
    if (aw_take) begin
      s_d.wr.aw_v = 1'b1;
      s_d.wr.aw_a = AWADDR;
    end
    if (w_take) begin
      s_d.wr.w_v = 1'b1;
      s_d.wr.w_d = WDATA;
      s_d.wr.w_s = WSTRB;
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end
    // Write execution
    if (wr_go) begin
      wd = s_q.wr.w_d[7:0];
      s_d.wr.aw_v = 1'b0;
      s_d.wr.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `ADCPT_OKAY;
      if (is_result(s_q.wr.aw_a)) begin
        if (s_q.ctrl2[`ADCPT_B_FASTCLR]) begin
          s_d.ccf[s_q.wr.aw_a[4:2]] = 1'b0;
        end
      end else if (!s_q.wr.w_s[0]) begin
        s_d.bresp = `ADCPT_OKAY;
      end else if (wr_idx == `ADCPT_IDX_CTRL2) begin
        // Flag bit keeps its value; it is not stored
        s_d.ctrl2 = wd & `ADCPT_CTRL2_WMASK;
        abort = 1'b1;
      end else if (wr_idx == `ADCPT_IDX_CTRL3) begin
        s_d.ctrl3 = wd;
        abort = 1'b1;
      end else if (wr_idx == `ADCPT_IDX_IRQ_STAT) begin
        s_d.irq_st = s_q.irq_st & ~wd[1:0];
      end else if (wr_idx == `ADCPT_IDX_IRQ_MASK) begin
        s_d.irq_mask = wd[1:0];
      end else if (wr_idx == `ADCPT_IDX_STAT2) begin
        s_d.bresp = `ADCPT_OKAY;
      end else begin
        s_d.bresp = `ADCPT_SLVERR;
      end
    end
    // Read execution
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `ADCPT_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (is_result(ARADDR)) begin
        rslot = ARADDR[4:2];
        s_d.rdata = {22'h00_0000, result_q[rslot]};
        if (s_q.ctrl2[`ADCPT_B_FASTCLR] || s_q.ccf_armed[rslot]) begin
          s_d.ccf[rslot] = 1'b0;
        end
        s_d.ccf_armed[rslot] = 1'b0;
      end else if (rd_idx == `ADCPT_IDX_CTRL2) begin
        s_d.rdata = {24'h00_0000, s_q.ctrl2[7:1], seq_flag};
      end else if (rd_idx == `ADCPT_IDX_CTRL3) begin
        s_d.rdata = {24'h00_0000, s_q.ctrl3};
      end else if (rd_idx == `ADCPT_IDX_STAT2) begin
        s_d.rdata = {24'h00_0000, s_q.ccf};
        s_d.ccf_armed = s_q.ccf;
      end else if (rd_idx == `ADCPT_IDX_IRQ_STAT) begin
        s_d.rdata = {30'h0000_0000, s_q.irq_st};
      end else if (rd_idx == `ADCPT_IDX_IRQ_MASK) begin
        s_d.rdata = {30'h0000_0000, s_q.irq_mask};
      end else begin
        s_d.rresp = `ADCPT_SLVERR;
      end
    end
    // Sequencer
    case (s_q.st)
      adcpt_pkg::ADCPT_OFF: begin
        if (s_q.ctrl2[`ADCPT_B_POWER]) begin
          s_d.st = adcpt_pkg::ADCPT_RECOVER;
          s_d.cnt = 16'(RECOVERY_CYC);
        end
      end
      adcpt_pkg::ADCPT_RECOVER: begin
        if (s_q.cnt <= 16'd1) begin
          s_d.st = adcpt_pkg::ADCPT_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 16'd1;
        end
      end
      adcpt_pkg::ADCPT_IDLE: begin
        if (trig_fire) begin
          s_d.st = adcpt_pkg::ADCPT_CONVERT;
          s_d.cnt = `ADCPT_CONV_CYC;
          s_d.done_cnt = 3'd0;
          s_d.sequence_complete_flag = 1'b0;
        end
      end
      adcpt_pkg::ADCPT_CONVERT: begin
        if (halt) begin
          s_d.halted = 1'b1;
        end else if (s_q.halted) begin
          s_d.halted = 1'b0;
        end else if (s_q.cnt <= 16'd1) begin
          s_d.ccf[s_q.slot] = 1'b1;
          s_d.slot = s_q.slot + 3'd1;
          s_d.cnt = `ADCPT_CONV_CYC;
          s_d.done_cnt = s_q.done_cnt + 3'd1;
          if (s_q.done_cnt == 3'(SEQ_LEN - 1)) begin
            s_d.st = adcpt_pkg::ADCPT_IDLE;
            s_d.sequence_complete_flag = 1'b1;
            s_d.irq_st[`ADCPT_IRQ_SEQ] = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt - 16'd1;
        end
      end
      default: begin
        s_d.st = adcpt_pkg::ADCPT_OFF;
      end
    endcase
    if (trig_fire && s_q.st != adcpt_pkg::ADCPT_OFF) begin
      s_d.irq_st[`ADCPT_IRQ_TRIG] = 1'b1;
    end
    // Abort from control writes: stop, no restart, slot back to zero
    if (abort) begin
      s_d.st = adcpt_pkg::ADCPT_IDLE;
      s_d.slot = 3'd0;
      s_d.done_cnt = 3'd0;
      s_d.halted = 1'b0;
    end
    // Power-down dominates everything
    if (!s_d.ctrl2[`ADCPT_B_POWER]) begin
      s_d.st = adcpt_pkg::ADCPT_OFF;
      s_d.halted = 1'b0;
    end else if (s_q.st == adcpt_pkg::ADCPT_OFF) begin
      s_d.st = adcpt_pkg::ADCPT_RECOVER;
      s_d.cnt = 16'(RECOVERY_CYC);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
      s_q.st <= adcpt_pkg::ADCPT_OFF;
      s_q.ctrl2 <= `ADCPT_CTRL2_RST;
      s_q.ctrl3 <= `ADCPT_CTRL3_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Result store for completed conversions
  always_ff @(posedge CLK) begin
    if (s_q.st == adcpt_pkg::ADCPT_CONVERT && !halt && !s_q.halted && s_q.cnt <= 16'd1) begin
      result_q[s_q.slot] <= RESULT_DATA;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign RVALID = s_q.rvalid;
  assign RDATA = s_q.rdata;
  assign RRESP = s_q.rresp;
  assign ANALOG_POWER = s_q.ctrl2[`ADCPT_B_POWER] && !halt;
  // Drops with the power in the very cycle that wait halts the converter
  assign CONV_ACTIVE = s_q.st == adcpt_pkg::ADCPT_CONVERT && !s_q.halted && !halt;
  assign RESULT_SLOT = s_q.slot;
  assign SEQ_IRQ = seq_flag;
  assign IRQ = |(s_q.irq_st & s_q.irq_mask);

endmodule : adcpt_ctrl
`default_nettype wire

// ### adcpt_defs.svh
// Purpose: Offsets, field positions and reset values of the converter control block
// Assumes: Registers reached over AXI4-Lite, one aligned word each
// Notes: Printed offsets are not multiples of four, so byte address is index times four
`ifndef ADCPT_DEFS_SVH
`define ADCPT_DEFS_SVH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define ADCPT_IDX_CTRL2 4'h2
`define ADCPT_IDX_CTRL3 4'h3
`define ADCPT_IDX_STAT2 4'h8
`define ADCPT_IDX_IRQ_STAT 4'h9
`define ADCPT_IDX_IRQ_MASK 4'hA
`define ADCPT_IDX_RESULT0 4'h0
`define ADCPT_RESULT_BASE 8'h40
`define ADCPT_ADDR_W 8

// ****************************************
// Control register two field positions
// ****************************************
`define ADCPT_B_POWER 7
`define ADCPT_B_FASTCLR 6
`define ADCPT_B_WAITPD 5
`define ADCPT_B_TRIGLE 4
`define ADCPT_B_TRIGP 3
`define ADCPT_B_TRIGE 2
`define ADCPT_B_IRQEN 1
`define ADCPT_B_IRQFLAG 0
`define ADCPT_CTRL2_WMASK 8'hFE
`define ADCPT_CTRL2_RST 8'h00
`define ADCPT_CTRL3_RST 8'h20

// ****************************************
// Interrupt status bits and timing
// ****************************************
`define ADCPT_IRQ_SEQ 0
`define ADCPT_IRQ_TRIG 1
`define ADCPT_RECOVERY_NS 20000
`define ADCPT_CLK_NS 8
`define ADCPT_RECOVERY_CYC ((`ADCPT_RECOVERY_NS + `ADCPT_CLK_NS - 1) / `ADCPT_CLK_NS)
`define ADCPT_CONV_CYC 16'h0020
`define ADCPT_OKAY 2'b00
`define ADCPT_SLVERR 2'b10

`endif

// ### adcpt_pkg.sv
// Purpose: Types of the converter control block
// Assumes: Used by package-qualified names only
// Notes: State of the top module, apart from the result registers, is one packed struct
package adcpt_pkg;

  // ****************************************
  // Sequence states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    ADCPT_OFF = 4'b0001,
    ADCPT_RECOVER = 4'b0010,
    ADCPT_IDLE = 4'b0100,
    ADCPT_CONVERT = 4'b1000
  } adcpt_state_t;

  // Pending bus write
  typedef struct packed {
    logic aw_v;
    logic [7:0] aw_a;
    logic w_v;
    logic [31:0] w_d;
    logic [3:0] w_s;
  } adcpt_wr_t;

  // Module state except the result registers
  typedef struct packed {
    adcpt_state_t st;
    logic [15:0] cnt;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] ccf;
    logic [7:0] ccf_armed;
    logic sequence_complete_flag;
    logic [2:0] slot;
    logic [2:0] done_cnt;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
    logic wait_s1;
    logic wait_s2;
    logic halted;
    adcpt_wr_t wr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcpt_state_all_t;

endpackage : adcpt_pkg

// ### adcpt_ctrl_props.sv
// Purpose: Port-level checks of the converter control block
// Assumes: One clock, reset active low
// Notes: Bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
module adcpt_ctrl_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Register bus
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RREADY,
  input wire logic [31:0] RDATA,
  // Converter side
  input wire logic ANALOG_POWER,
  input wire logic CONV_ACTIVE,
  input wire logic [2:0] RESULT_SLOT
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  rst_off_a: assert property ($rose(RSTN) |-> !ANALOG_POWER && !CONV_ACTIVE)
    else $error("converter not off after reset");
  pwr_conv_a: assert property (CONV_ACTIVE |-> ANALOG_POWER)
    else $error("converting while powered down");
  abort_ctl2_a: assert property (AWVALID && AWREADY && WVALID && WREADY && WSTRB[0]
    && AWADDR == 8'h08 |-> ##[1:3] RESULT_SLOT == 3'h0) else $error("ctrl2 write no abort");
  abort_ctl3_a: assert property (AWVALID && AWREADY && WVALID && WREADY && WSTRB[0]
    && AWADDR == 8'h0C |-> ##[1:3] RESULT_SLOT == 3'h0) else $error("ctrl3 write no abort");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped early");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  r_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  wr_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
endmodule : adcpt_ctrl_props
bind adcpt_ctrl adcpt_ctrl_props u_props (.*);
`default_nettype wire

// ### adcpt_trig_src.sv
// Purpose: External trigger source on channel 7
// Assumes: Bench commands each event with fire
// Notes: Idle level is the inverse of the active level
`timescale 1ns/1ns
`default_nettype none
module adcpt_trig_src (
  // Command
  input wire logic [1:0] mode,
  input wire logic fire,
  // Pin
  output logic trig
);
  // Active level is the polarity bit; edge modes see the move into it
  assign trig = fire ? mode[0] : ~mode[0];
endmodule : adcpt_trig_src
`default_nettype wire

// ### adcpt_tb_top.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Recovery shortened to 4 cycles, four conversions a sequence
// Notes: Channel 7 results are never judged while triggering
`timescale 1ns/1ns
`default_nettype none
module adcpt_tb_top;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, apow, cact, irq, sirq, trig;
  logic [1:0] bresp, rresp, r, mode = 0;
  logic [2:0] slot;
  logic [9:0] rdv = 0;
  logic wmode = 0, fire = 0;
  int bad_count = 0, checked = 0, seed = 95, i, m2, ccf;
  always #4 clk = ~clk;
  adcpt_ctrl #(.RECOVERY_CYC(4), .SEQ_LEN(4)) u_dut (.CLK(clk), .RSTN(rstn),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
    .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .TRIG_CH7(trig), .WAIT_MODE(wmode),
    .RESULT_DATA(rdv), .ANALOG_POWER(apow), .CONV_ACTIVE(cact), .RESULT_SLOT(slot),
    .IRQ(irq), .SEQ_IRQ(sirq));
  adcpt_trig_src u_src (.mode(mode), .fire(fire), .trig(trig));
  // Compare one value
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // Bus write, both halves offered together
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ga, gw, gb;
    ga = 0;
    gw = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ga && gw)) begin
      #1 ga = ga | awready;
      gw = gw | wready;
      @(posedge clk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
    end
    do begin
      #1 gb = bvalid;
      r = bresp;
      @(posedge clk);
    end while (!gb);
    bready <= 1'b0;
  endtask : wr
  // Bus read, result left in d and r
  task rd(input logic [7:0] a);
    logic g;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1 g = arready;
      @(posedge clk);
    end while (!g);
    arvalid <= 1'b0;
    do begin
      #1 g = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end while (!g);
    rready <= 1'b0;
  endtask : rd
  // Start a sequence by one trigger event
  task fire_once;
    @(posedge clk) fire <= 1'b1;
    for (i = 0; i < 20 && cact !== 1'b1; i++) @(negedge clk);
    chk(cact, 1);
    @(posedge clk) fire <= 1'b0;
  endtask : fire_once
  // Verdict and end of run
  task stop_test;
    if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdv <= 10'($random(seed));
    rd(8'h08);
    chk(d, 0);
    rd(8'h0C);
    chk(d, 32'h20);
    rd(8'h30);
    chk(r, 2);
    chk(d, 0);
    m2 = $random(seed) & 8'h7A;
    wr(8'h08, m2 | 1);
    rd(8'h08);
    chk(d, m2);
    wr(8'h28, 1);
    // Every trigger sensitivity, interrupt on and off
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) mode <= k[1:0];
      m2 = 8'h86 | (k << 3);
      wr(8'h08, m2);
      repeat (20) @(negedge clk);
      chk(cact, 0);
      fire_once();
      for (i = 0; i < 300 && slot !== 3'h4; i++) @(negedge clk);
      chk({sirq, irq, slot}, 5'b11100);
      rd(8'h08);
      chk(d, m2 | 1);
      wr(8'h24, 3);
      wr(8'h08, m2 & 8'hF9);
      @(negedge clk);
      chk({sirq, irq, slot}, 5'b00000);
      rd(8'h08);
      chk(d, m2 & 8'hF9);
    end
    // Abort in mid-sequence by either control write
    for (int k = 0; k < 2; k++) begin
      wr(8'h08, 8'h9C);
      repeat (20) @(negedge clk);
      fire_once();
      repeat (40) @(negedge clk);
      chk(slot, 1);
      wr(k ? 8'h0C : 8'h08, k ? 32'h20 : 32'h9C);
      repeat (50) @(negedge clk);
      chk({cact, slot}, 4'h0);
    end
    // Flag clearing, normal then fast
    ccf = 15;
    rd(8'h44);
    chk(d, rdv);
    rd(8'h20);
    chk(d, ccf);
    rd(8'h40);
    chk(d, rdv);
    ccf = ccf & 14;
    rd(8'h20);
    chk(d, ccf);
    wr(8'h08, 8'hC0);
    wr(8'h4C, 0);
    ccf = ccf & 7;
    rd(8'h20);
    chk(d, ccf);
    // Wait mode with and without power-down
    for (int k = 0; k < 2; k++) begin
      wr(8'h08, k ? 8'h80 : 8'hA0);
      repeat (10) @(negedge clk);
      chk(apow, 1);
      @(posedge clk) wmode <= 1'b1;
      repeat (6) @(negedge clk);
      chk(apow, k);
      @(posedge clk) wmode <= 1'b0;
      repeat (6) @(negedge clk);
      chk(apow, 1);
    end
    wr(8'h08, 0);
    @(negedge clk);
    chk(apow, 0);
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule : adcpt_tb_top
`default_nettype wire
